// ---- rtl/pvs_pkg.sv ----
// ****************************************************************
// pin volume converter constants and types
// ****************************************************************
package pvs_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] PVS_CTRL_OFS = 8'h74;  // converter control
  localparam logic [7:0] PVS_GAIN_OFS = 8'h75;  // gain readback
  localparam logic [7:0] PVS_CTRL_RST = 8'h00;  // control reset value
  localparam logic [7:0] PVS_RD_ZERO  = 8'h00;  // unmapped read answer

  // ****************************************************************
  // gain code limits
  // ****************************************************************
  localparam logic [6:0] PVS_GAIN_RST  = 7'h00;  // 18 dB after reset
  localparam logic [6:0] PVS_GAIN_MAX  = 7'h7E;  // lowest legal gain
  localparam logic [6:0] PVS_GAIN_RSVD = 7'h7F;  // reserved code
  localparam logic [6:0] PVS_SAR_MSB   = 7'h40;  // first trial bit

  // ****************************************************************
  // conversion timing
  // ****************************************************************
  localparam longint PVS_MCLK_HZ         = 12000000;  // reference master clock
  localparam longint PVS_BASE_RATE_MILHZ = 15625;     // slowest rate, millihertz
  localparam int     PVS_CONV_TICKS_DFLT = int'((PVS_MCLK_HZ * 1000) / PVS_BASE_RATE_MILHZ);

  // ****************************************************************
  // control register layout
  // ****************************************************************
  typedef struct packed {
    logic       volFromPin;  // 1: gain from pin, converter powered
    logic       clkSelMclk;  // 1: master clock, 0: rc oscillator
    logic [1:0] hyst;        // hysteresis in code steps
    logic       rsvd;        // reserved, held as written
    logic [2:0] rate;        // throughput, doubles per step
  } pvs_ctrl_t;

  typedef enum logic [0:0] {
    PVS_IDLE,
    PVS_CONV
  } pvs_sar_state_t;

endpackage : pvs_pkg

// ---- rtl/pvs_sar.sv ----
// ****************************************************************
// 7-bit successive approximation sequencer
// ****************************************************************
module pvs_sar
  import pvs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       powerUp,
  input  wire logic       start,
  // comparator from analogue side
  input  wire logic       compHigh,
  // trial code and result
  output logic [6:0]      trial,
  output logic [6:0]      result,
  output logic            done,
  output logic            busy
);

  pvs_sar_state_t state, next_state;
  logic [6:0]     mask, next_mask;
  logic [6:0]     next_trial, next_result;
  logic           next_done;

  // one bit decided per clock, msb first
  always_comb begin
    next_state  = state;
    next_mask   = mask;
    next_trial  = trial;
    next_result = result;
    next_done   = 1'b0;
    case (state)
      PVS_IDLE: begin
        if (powerUp && start) begin
          next_state = PVS_CONV;
          next_mask  = PVS_SAR_MSB;
          next_trial = PVS_SAR_MSB;
        end
      end
      PVS_CONV: begin
        if (!compHigh) begin
          next_trial = trial & ~mask;  // pin below trial, drop bit
        end
        if (mask[0]) begin
          next_state  = PVS_IDLE;
          next_result = next_trial;
          next_done   = 1'b1;
        end else begin
          next_trial = next_trial | (mask >> 1);
          next_mask  = mask >> 1;
        end
        if (!powerUp) begin
          next_state = PVS_IDLE;  // powered down mid conversion
          next_done  = 1'b0;
        end
      end
      default: next_state = PVS_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state  <= PVS_IDLE;
      mask   <= 7'h00;
      trial  <= 7'h00;
      result <= 7'h00;
      done   <= 1'b0;
      busy   <= 1'b0;
    end else begin
      state  <= next_state;
      mask   <= next_mask;
      trial  <= next_trial;
      result <= next_result;
      done   <= next_done;
      busy   <= (next_state == PVS_CONV);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // conversion request taken in idle
  sequence conv_start_s;
    state == PVS_IDLE && powerUp && start;
  endsequence

  // converter left powered for all seven steps
  sequence powered_s;
    powerUp [*7];
  endsequence

  // busy through the seven compare cycles
  sequence conv_steps_s;
    busy [*7];
  endsequence

  seven_steps_a : assert property (@(posedge clk) disable iff (!rst_b)
    conv_start_s ##1 conv_steps_s |=> !busy)
    else $error("sar step count wrong");

  conv_length_a : assert property (@(posedge clk) disable iff (!rst_b)
    conv_start_s ##1 powered_s |-> ##1 done)
    else $error("sar did not finish after seven steps");

  // busy from first to last step
  conv_busy_a : assert property (@(posedge clk) disable iff (!rst_b)
    conv_start_s ##1 powered_s |-> busy && $past(busy, 6))
    else $error("sar not busy while converting");

endmodule : pvs_sar

// ---- rtl/pvs_control.sv ----
// Summary of operation
// - volume source bit 0: register volume, converter held powered down
// - clock select bit picks rc oscillator at 0, master clock at 1
// - hysteresis field: none, plus or minus one, two or three codes
// - throughput field halves the conversion period per step from code 000
// - on the rc oscillator the same divider scales with its frequency
// - read-only 7-bit gain code, 0 is 18 dB, half dB steps
// - from code 5B steps are 1 dB, code 7F is reserved
module pvs_control
  import pvs_pkg::*;
#(
  parameter logic [19:0] CONV_BASE_TICKS = 20'(PVS_CONV_TICKS_DFLT)
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRd,
  output logic [7:0]      regRdData,
  // converter timing and analogue side
  input  wire logic       rcTick,
  input  wire logic       compHigh,
  output logic [6:0]      sarTrial,
  output logic            adcPowerUp,
  output logic            adcClkMclk,
  // playback gain
  output logic [6:0]      pinGain,
  output logic            pinVolumeSel
);

  // ****************************************************************
  // state
  // ****************************************************************
  pvs_ctrl_t   ctrl, next_ctrl;
  logic [19:0] tickCnt, next_tickCnt;
  logic        convStart, next_convStart;
  logic [6:0]  next_pinGain;
  logic [7:0]  next_regRdData;
  logic        next_adcPowerUp, next_adcClkMclk, next_pinVolumeSel;

  // combinational helpers
  logic [19:0] ratePeriod;
  logic        srcTick;
  logic [6:0]  sarResult, newCode, diffAbs, hystAmt;
  logic        sarDone, sarBusy;

  // ****************************************************************
  // converter sequencer
  // ****************************************************************
  pvs_sar u_sar (
    .clk      (clk),
    .rst_b    (rst_b),
    .powerUp  (ctrl.volFromPin),
    .start    (convStart),
    .compHigh (compHigh),
    .trial    (sarTrial),
    .result   (sarResult),
    .done     (sarDone),
    .busy     (sarBusy)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  always_comb begin
    srcTick    = ctrl.clkSelMclk | rcTick;
    ratePeriod = CONV_BASE_TICKS >> ctrl.rate;
    newCode    = (sarResult == PVS_GAIN_RSVD) ? PVS_GAIN_MAX : sarResult;
    diffAbs    = (newCode >= pinGain) ? 7'(newCode - pinGain) : 7'(pinGain - newCode);
    hystAmt    = {5'h00, ctrl.hyst};
  end

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb begin
    next_ctrl      = ctrl;
    next_tickCnt   = tickCnt;
    next_convStart = 1'b0;
    next_pinGain   = pinGain;
    next_regRdData = regRdData;
    // register writes; gain readback ignores writes
    if (regWr && regAddr == PVS_CTRL_OFS) begin
      next_ctrl = pvs_ctrl_t'(regWrData);
    end
    // register reads, unmapped reads give zero
    if (regRd) begin
      case (regAddr)
        PVS_CTRL_OFS: next_regRdData = ctrl;
        PVS_GAIN_OFS: next_regRdData = {1'b0, pinGain};
        default:      next_regRdData = PVS_RD_ZERO;
      endcase
    end
    // no conversions while register volume is used
    if (!ctrl.volFromPin) begin
      next_tickCnt = 20'h00000;
    // rc ticks or master clock advance the divider
    end else if (srcTick) begin
      if (tickCnt >= ratePeriod - 20'h00001) begin
        next_tickCnt   = 20'h00000;
        next_convStart = 1'b1;
      end else begin
        next_tickCnt = tickCnt + 20'h00001;
      end
    end
    // update only beyond the hysteresis window
    if (sarDone && ctrl.volFromPin && diffAbs > hystAmt) begin
      next_pinGain = newCode;
    end
    next_adcPowerUp   = next_ctrl.volFromPin;
    next_pinVolumeSel = next_ctrl.volFromPin;
    next_adcClkMclk   = next_ctrl.clkSelMclk;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl         <= pvs_ctrl_t'(PVS_CTRL_RST);
      tickCnt      <= 20'h00000;
      convStart    <= 1'b0;
      pinGain      <= PVS_GAIN_RST;
      regRdData    <= PVS_RD_ZERO;
      adcPowerUp   <= 1'b0;
      adcClkMclk   <= 1'b0;
      pinVolumeSel <= 1'b0;
    end else begin
      ctrl         <= next_ctrl;
      tickCnt      <= next_tickCnt;
      convStart    <= next_convStart;
      pinGain      <= next_pinGain;
      regRdData    <= next_regRdData;
      adcPowerUp   <= next_adcPowerUp;
      adcClkMclk   <= next_adcClkMclk;
      pinVolumeSel <= next_pinVolumeSel;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  power_down_a : assert property (!ctrl.volFromPin |-> (!adcPowerUp && !pinVolumeSel)
    ##1 (!convStart && !sarBusy))
    else $error("converter active while register volume selected");

  // rc source without tick holds divider
  rc_hold_a : assert property (!ctrl.clkSelMclk && !rcTick |=> $stable(tickCnt) || tickCnt == 20'h00000)
    else $error("divider moved without an rc tick");

  // start only at end of period
  rate_start_a : assert property (convStart |-> $past(tickCnt) == $past(ratePeriod) - 20'h00001
    && $past(srcTick))
    else $error("conversion started off period");

  // rc tick advances divider by one
  rc_step_a : assert property (ctrl.volFromPin && !ctrl.clkSelMclk && rcTick
    && tickCnt < ratePeriod - 20'h00001 && !regWr |=> tickCnt == $past(tickCnt) + 20'h00001)
    else $error("rc tick not counted");

  hyst_move_a : assert property ($changed(pinGain) |-> $past(sarDone)
    && $past(diffAbs) > $past(hystAmt))
    else $error("gain moved inside hysteresis");

  hyst_hold_a : assert property (sarDone && diffAbs <= hystAmt |=> $stable(pinGain))
    else $error("gain updated within hysteresis window");

  gain_rsvd_a : assert property (pinGain != PVS_GAIN_RSVD)
    else $error("reserved gain code reported");

  // readback shows gain, top bit zero
  gain_read_a : assert property (regRd && regAddr == PVS_GAIN_OFS |=> regRdData == {1'b0, $past(pinGain)})
    else $error("gain readback mismatch");

  ctrl_read_a : assert property (regRd && regAddr == PVS_CTRL_OFS |=> regRdData == $past(ctrl))
    else $error("control readback mismatch");

  gain_follow_a : assert property (sarDone && ctrl.volFromPin && ctrl.hyst == 2'b00
    && sarResult != PVS_GAIN_RSVD |=> pinGain == $past(sarResult))
    else $error("gain did not follow result without hysteresis");

  // reserved result shown as lowest gain
  rsvd_clamp_a : assert property (sarDone && ctrl.volFromPin && sarResult == PVS_GAIN_RSVD
    && pinGain < PVS_GAIN_MAX - 7'h03 |=> pinGain == PVS_GAIN_MAX)
    else $error("reserved result not clamped");

  write_ignore_a : assert property (regWr && regAddr == PVS_GAIN_OFS && !sarDone |=> $stable(pinGain))
    else $error("gain changed by a register write");

  // clock and source outputs follow control
  clk_out_a : assert property (adcClkMclk == ctrl.clkSelMclk && pinVolumeSel == ctrl.volFromPin)
    else $error("converter clock or source output wrong");

  // starts only while pin volume selected
  start_power_a : assert property (convStart |-> $past(ctrl.volFromPin))
    else $error("conversion started with register volume");

endmodule : pvs_control

// ---- test/pvs_pot_model.sv ----
// ****************************************************************
// analogue volume pin and comparator model
// ****************************************************************
module pvs_pot_model
  import pvs_pkg::*;
(
  // dac trial and pin level
  input  wire logic [6:0] sarTrial,
  input  wire logic [6:0] potLevel,
  // comparator
  output logic            compHigh
);
  timeunit 1ns;
  timeprecision 1ns;

  // high while the pin sits at or above the trial code
  assign compHigh = (potLevel >= sarTrial);

endmodule : pvs_pot_model

// ---- test/test_pvs_control.sv ----
// ****************************************************************
// pin volume control bench
// ****************************************************************
module test_pvs_control;
  import pvs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BASE = 1024;  // shortened slowest period

  logic        clk          = 1'b0;
  logic        rst_b        = 1'b0;
  logic [7:0]  regAddr      = 8'h00;
  logic        regWr        = 1'b0;
  logic [7:0]  regWrData    = 8'h00;
  logic        regRd        = 1'b0;
  logic [7:0]  regRdData;
  logic        rcTick       = 1'b0;
  logic        rcOn         = 1'b0;
  logic        compHigh;
  logic [6:0]  sarTrial;
  logic [6:0]  potLevel     = 7'h00;
  logic        adcPowerUp;
  logic        adcClkMclk;
  logic [6:0]  pinGain;
  logic        pinVolumeSel;
  int          num_errors   = 0;
  int          num_checks   = 0;
  logic [15:0] rd;
  int          n;

  // rows avoid hysteresis code 11, keep control bit 3 zero
  // rows: control, rc ticks on, pin level, expected gain
  logic [7:0]  ctrlRow [13] = '{8'hC7, 8'hC7, 8'hC7, 8'hC7, 8'hC7, 8'hD7, 8'hD7, 8'hE7, 8'hE7, 8'h87, 8'h87,
                                8'h07, 8'h47};
  logic [12:0] rcRow        = 13'h0200;
  logic [6:0]  lvlRow  [13] = '{7'h24, 7'h00, 7'h5B, 7'h7F, 7'h20, 7'h21, 7'h22, 7'h24, 7'h25, 7'h30, 7'h40,
                                7'h50, 7'h50};
  logic [6:0]  gainRow [13] = '{7'h24, 7'h00, 7'h5B, 7'h7E, 7'h20, 7'h20, 7'h22, 7'h22, 7'h25, 7'h30, 7'h30,
                                7'h30, 7'h30};

  // clock and rc oscillator ticks every other cycle
  always #50 clk = ~clk;
  always @(negedge clk) begin
    rcTick <= rcOn & ~rcTick;
  end

  pvs_control #(.CONV_BASE_TICKS(20'(BASE))) dut_u (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRd(regRd),
    .regRdData(regRdData), .rcTick(rcTick), .compHigh(compHigh), .sarTrial(sarTrial),
    .adcPowerUp(adcPowerUp), .adcClkMclk(adcClkMclk), .pinGain(pinGain), .pinVolumeSel(pinVolumeSel)
  );

  pvs_pot_model pot_u (.sarTrial(sarTrial), .potLevel(potLevel), .compHigh(compHigh));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge clk);
    regWr = 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk);
    regRd = 1'b0;
    @(negedge clk);
    rd = {8'h00, regRdData};
  endtask : rdreg

  // cycles until the next conversion start
  task automatic waitStart();
    logic prev;
    prev = 1'b1;
    n = 0;
    while (n < 2100 && !(sarTrial === 7'h40 && !prev)) begin
      prev = (sarTrial === 7'h40);
      @(negedge clk);
      n++;
    end
  endtask : waitStart

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    rdreg(PVS_CTRL_OFS);
    check(rd, 16'(PVS_CTRL_RST), "ctrl reset");
    rdreg(PVS_GAIN_OFS);
    check(rd, 16'h0000, "gain reset");
    // level changes only while the converter is off
    for (int i = 0; i < 13; i++) begin
      rcOn = rcRow[i];
      wr(PVS_CTRL_OFS, ctrlRow[i] & 8'h7F);
      potLevel = lvlRow[i];
      wr(PVS_CTRL_OFS, ctrlRow[i]);
      repeat (200) @(negedge clk);
      check(16'(pinGain), 16'(gainRow[i]), "gain");
      check(16'({adcPowerUp, adcClkMclk, pinVolumeSel}), 16'({ctrlRow[i][7:6], ctrlRow[i][7]}), "ctl");
      rdreg(PVS_CTRL_OFS);
      check(rd, 16'(ctrlRow[i]), "ctrl readback");
      rdreg(PVS_GAIN_OFS);
      check(rd, 16'(gainRow[i]), "gain readback");
    end
    wr(PVS_GAIN_OFS, 8'h00);
    rdreg(PVS_GAIN_OFS);
    check(rd, 16'h0030, "gain after write");
    rdreg(8'h76);
    check(rd, 16'(PVS_RD_ZERO), "unmapped");
    // conversion period per throughput code
    potLevel = 7'h10;
    for (int r = 0; r < 8; r++) begin
      wr(PVS_CTRL_OFS, 8'hC0 | 8'(r));
      waitStart();
      waitStart();
      check(16'(n), 16'(BASE >> r), "period");
    end
    rcOn = 1'b1;
    wr(PVS_CTRL_OFS, 8'h87);
    waitStart();
    waitStart();
    check(16'(n), 16'(2 * (BASE >> 7)), "rc period");
    // reset in mid-run
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    check(16'(pinGain), 16'h0000, "gain after reset");
    check(16'({adcPowerUp, adcClkMclk, pinVolumeSel, sarTrial}), 16'h0000, "outputs after reset");
    check(16'(regRdData), 16'(PVS_RD_ZERO), "read data after reset");
    rdreg(PVS_CTRL_OFS);
    check(rd, 16'(PVS_CTRL_RST), "ctrl after reset");
    stop_test();
  end

endmodule : test_pvs_control
